// File: rtl/umf_pkg.sv
// package of constants for the multidrop-filtering serial port
// Notes on behaviour
// - filter on: data frames are discarded
// - 5-8 bit: first stop bit marks type
// - 9 bit: ninth data bit marks type
// - type one is address, zero data
// - transmitter ignores the filter enable bit
// - address frames stored, complete flag set
// - filter off: accept data until next address
// - one character size for both directions
// - rate error margin larger for a slow sender than a fast one
// - sample 16x normal, 8x double speed
package umf_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] UMF_CTRL_STATUS_A = 12'h000; // serial_ctrl_status_a
    localparam logic [11:0] UMF_CTRL_B        = 12'h004;
    localparam logic [11:0] UMF_DATA          = 12'h008; // serial_data_buffer
    localparam logic [11:0] UMF_DIVISOR       = 12'h00c; // baud_divisor
    // ****************************************
    // field positions in status a
    // ****************************************
    localparam int UMF_A_FILTER = 0;
    localparam int UMF_A_DSPEED = 1;
    localparam int UMF_A_FERR   = 4;
    localparam int UMF_A_TXC    = 6;
    localparam int UMF_A_RXC    = 7;
    // ****************************************
    // field positions in control b
    // ****************************************
    localparam int UMF_B_TX8    = 0;
    localparam int UMF_B_RX8    = 1;
    localparam int UMF_B_SIZE   = 2;  // 3 bits
    localparam int UMF_B_STOP2  = 5;
    localparam int UMF_B_TXEN   = 6;
    localparam int UMF_B_RXEN   = 7;
    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0]  UMF_RST_A       = 8'h20;
    localparam logic [7:0]  UMF_RST_B       = 8'h18;  // size field 6, decoded as 11 data bits
    localparam logic [11:0] UMF_RST_DIVISOR = 12'h000;
    localparam logic [2:0]  UMF_SIZE_9BIT   = 3'h7;
    localparam logic [4:0]  UMF_OVS_NORMAL  = 5'h10;
    localparam logic [4:0]  UMF_OVS_DOUBLE  = 5'h08;
    typedef enum logic [1:0] {
        UMF_RX_IDLE  = 2'b00,
        UMF_RX_START = 2'b01,
        UMF_RX_BITS  = 2'b10
    } umf_rx_state_t;
endpackage : umf_pkg

// File: rtl/umf_sampler.sv
// majority-vote bit sampler driven by the oversample tick
`timescale 1ns/1ns
module umf_sampler
    import umf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       dspeed,
    input  wire logic       line,
    output logic            bitDone,
    output logic            bitVal
);
    logic [4:0] phase_q;
    logic [2:0] votes_q;
    logic [4:0] ovs;
    logic [4:0] first;
    logic       atEnd;
    logic       inWindow;

    // three centre samples at 8,9,10 or 4,5,6 counting from one
    assign ovs      = dspeed ? UMF_OVS_DOUBLE : UMF_OVS_NORMAL;
    assign first    = ovs >> 1;
    assign atEnd    = (phase_q == ovs - 5'h01);
    // votes sit just past the bit centre, giving a slow sender more margin than a fast one
    assign inWindow = (phase_q + 5'h01 >= first) && (phase_q + 5'h01 <= first + 5'h02);

    // phase counter and vote collector
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            phase_q <= 5'h00;
            votes_q <= 3'h0;
            bitDone <= 1'b0;
            bitVal  <= 1'b1;
        end else begin
            bitDone <= 1'b0;
            if (tick) begin
                if (inWindow) begin
                    votes_q <= {votes_q[1:0], line};
                end
                if (atEnd) begin
                    phase_q <= 5'h00;
                    bitDone <= 1'b1;
                    bitVal  <= (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2]) | (votes_q[1] & votes_q[2]);
                end else begin
                    phase_q <= phase_q + 5'h01;
                end
            end
        end
    end
endmodule // umf_sampler

// File: rtl/umf_top.sv
// serial port with multidrop address filter behind an apb slave
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module umf_top
    import umf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxLine,
    output logic             txLine
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  ctrlA_q;
    logic [7:0]  ctrlB_q;
    logic [11:0] divisor_q;
    logic [7:0]  rxData_q;
    logic        rxFull_q;
    logic        rx8_q;
    logic        ferr_q;
    logic        txc_q;

    // ****************************************
    // bus decode
    // ****************************************
    logic access;
    logic wrEn;
    logic rdData;
    logic hitA;
    logic hitB;
    logic hitD;
    logic hitV;
    logic mapped;
    assign access = psel & penable;
    assign hitA   = (paddr == UMF_CTRL_STATUS_A);
    assign hitB   = (paddr == UMF_CTRL_B);
    assign hitD   = (paddr == UMF_DATA);
    assign hitV   = (paddr == UMF_DIVISOR);
    assign mapped = hitA | hitB | hitD | hitV;
    assign wrEn   = access & pwrite & mapped;
    assign rdData = access & ~pwrite & hitD;

    logic [7:0] statusA;
    logic [7:0] statusB;
    logic [31:0] rdMux;
    assign statusA = {rxFull_q, txc_q, 1'b0, ferr_q, 2'b00, ctrlA_q[UMF_A_DSPEED], ctrlA_q[UMF_A_FILTER]};
    assign statusB = {ctrlB_q[7:2], rx8_q, ctrlB_q[UMF_B_TX8]};
    assign rdMux   = hitA ? {24'h000000, statusA} :
                     hitB ? {24'h000000, statusB} :
                     hitD ? {24'h000000, rxData_q} :
                     hitV ? {20'h00000, divisor_q} : 32'h00000000;

    // apb answer: zero wait states, error on unmapped address
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= rdMux;
        end
    end

    // ****************************************
    // baud tick divider
    // ****************************************
    logic [11:0] baudCnt_q;
    logic        tick;
    assign tick = (baudCnt_q == 12'h000);
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            baudCnt_q <= divisor_q;
        end else begin
            baudCnt_q <= baudCnt_q - 12'h001;
        end
    end

    // one size field serves both directions
    logic [2:0] size;
    logic       nine;
    logic [3:0] dataBits;
    logic       filterOn;
    logic       dspeed;
    assign size     = ctrlB_q[UMF_B_SIZE +: 3];
    assign nine     = (size == UMF_SIZE_9BIT);
    assign dataBits = nine ? 4'h9 : {1'b0, size} + 4'h5;
    assign filterOn = ctrlA_q[UMF_A_FILTER];
    assign dspeed   = ctrlA_q[UMF_A_DSPEED];

    // ****************************************
    // receiver
    // ****************************************
    umf_rx_state_t rxState_q;
    umf_rx_state_t rxState_d;
    logic [3:0] rxIdx_q;
    logic [8:0] rxShift_q;
    logic       bitDone;
    logic       bitVal;
    logic       restart;
    logic       rxOn;
    assign rxOn    = ctrlB_q[UMF_B_RXEN];
    assign restart = (rxState_q == UMF_RX_IDLE);

    umf_sampler uSampler (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick),
        .restart (restart),
        .dspeed  (dspeed),
        .line    (rxLine),
        .bitDone (bitDone),
        .bitVal  (bitVal)
    );

    // frame type and acceptance decisions
    logic stopSeen;
    logic frameType;
    logic keep;
    logic lastBit;
    assign lastBit   = (rxIdx_q == dataBits);
    assign stopSeen  = (rxState_q == UMF_RX_BITS) && bitDone && lastBit;
    // 9-bit uses the ninth bit, else the first stop bit
    assign frameType = nine ? rxShift_q[8] : bitVal;
    // one is address; data dropped only while filtering
    assign keep      = ~filterOn | frameType;

    always_comb begin
        rxState_d = rxState_q;
        case (rxState_q)
            UMF_RX_IDLE:  if (rxOn && !rxLine) rxState_d = UMF_RX_START;
            UMF_RX_START: if (bitDone) rxState_d = bitVal ? UMF_RX_IDLE : UMF_RX_BITS;
            UMF_RX_BITS:  if (stopSeen) rxState_d = UMF_RX_IDLE;
            default:      rxState_d = UMF_RX_IDLE;
        endcase
        if (!rxOn) rxState_d = UMF_RX_IDLE;
    end

    // shift in lsb first, index counts data bits then stop
    always_ff @(posedge clk) begin
        if (rst) begin
            rxState_q <= UMF_RX_IDLE;
            rxIdx_q   <= 4'h0;
            rxShift_q <= 9'h000;
        end else begin
            rxState_q <= rxState_d;
            if (rxState_q != UMF_RX_BITS) begin
                rxIdx_q   <= 4'h0;
                rxShift_q <= 9'h000;                              // short characters must not keep old upper bits
            end else if (bitDone && !lastBit) begin
                rxShift_q[rxIdx_q] <= bitVal;
                rxIdx_q            <= rxIdx_q + 4'h1;
            end
        end
    end

    // receive buffer: the set wins over the read that empties it
    always_ff @(posedge clk) begin
        if (rst) begin
            rxData_q <= 8'h00;
            rx8_q    <= 1'b0;
            ferr_q   <= 1'b0;
            rxFull_q <= 1'b0;
        end else if (stopSeen && keep) begin
            rxData_q <= rxShift_q[7:0];
            rx8_q    <= rxShift_q[8];
            ferr_q   <= ~bitVal & nine;
            rxFull_q <= 1'b1;
        end else if (rdData || !rxOn) begin
            rxFull_q <= 1'b0;
        end
    end

    // ****************************************
    // transmitter, never looks at the filter bit
    // ****************************************
    logic [11:0] txFrame_q;
    logic [3:0]  txLeft_q;
    logic [4:0]  txPh_q;
    logic        txBusy;
    logic        txLoad;
    logic [4:0]  ovs;
    logic [3:0]  txLen;
    logic [11:0] txPat;
    assign ovs    = dspeed ? UMF_OVS_DOUBLE : UMF_OVS_NORMAL;
    assign txBusy = (txLeft_q != 4'h0);
    assign txLoad = access & pwrite & hitD & ~txBusy & ctrlB_q[UMF_B_TXEN];
    assign txLen  = dataBits + (ctrlB_q[UMF_B_STOP2] ? 4'h3 : 4'h2);
    // pattern: start, data, ninth, stops padded with ones
    // short sizes: every position above the last data bit is forced to a stop one
    assign txPat  = nine ? {1'b1, 1'b1, ctrlB_q[UMF_B_TX8], pwdata[7:0], 1'b0} :
                    ({3'h7, pwdata[7:0], 1'b0} | (12'hffe << dataBits));

    always_ff @(posedge clk) begin
        if (rst) begin
            txFrame_q <= 12'hfff;
            txLeft_q  <= 4'h0;
            txPh_q    <= 5'h00;
            txLine    <= 1'b1;
        end else if (txLoad) begin
            txFrame_q <= txPat;
            txLeft_q  <= txLen;
            txPh_q    <= 5'h00;
            txLine    <= txPat[0];
        end else if (txBusy && tick) begin
            if (txPh_q == ovs - 5'h01) begin
                txPh_q    <= 5'h00;
                txFrame_q <= {1'b1, txFrame_q[11:1]};
                txLeft_q  <= txLeft_q - 4'h1;
                txLine    <= (txLeft_q == 4'h1) ? 1'b1 : txFrame_q[1];
            end else begin
                txPh_q <= txPh_q + 5'h01;
            end
        end
    end

    // ****************************************
    // control registers and transmit-complete flag
    // ****************************************
    logic txEnd;
    logic txcClr;
    assign txEnd  = txBusy && tick && (txPh_q == ovs - 5'h01) && (txLeft_q == 4'h1);
    // writing one clears it; a whole-register write is needed to change the filter bit safely
    assign txcClr = wrEn & hitA & pwdata[UMF_A_TXC];
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlA_q   <= UMF_RST_A;
            ctrlB_q   <= UMF_RST_B;
            divisor_q <= UMF_RST_DIVISOR;
            txc_q     <= 1'b0;
        end else begin
            if (wrEn && hitA) ctrlA_q <= pwdata[7:0];
            if (wrEn && hitB) ctrlB_q <= pwdata[7:0];
            if (wrEn && hitV) divisor_q <= pwdata[11:0];
            if (txEnd) begin
                txc_q <= 1'b1;
            end else if (txcClr) begin
                txc_q <= 1'b0;
            end
        end
    end
endmodule // umf_top

// File: verification/umf_top_asserts.sv
// assertions on the apb and serial ports of the filter block
`timescale 1ns/1ns
module umf_top_asserts
    import umf_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxLine,
    input wire logic        txLine
);
    // ****************
    // decode
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // only four word offsets answer without error
    wire logic mapped = paddr inside {UMF_CTRL_STATUS_A, UMF_CTRL_B, UMF_DATA, UMF_DIVISOR};
    // ****************
    // properties
    // ****************
    property p_rdy_access; pready |-> psel && penable; endproperty
    a_rdy_access: assert property (p_rdy_access) else $error("pready outside access phase");
    property p_zero_wait; psel && !penable |=> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access phase not answered at once");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_err_map; pready |-> pslverr == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr does not match decode");
    property p_err_only; pslverr |-> pready; endproperty
    a_err_only: assert property (p_err_only) else $error("pslverr without pready");
    property p_rd_upper; pready && !pwrite |-> prdata[31:12] == 20'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    property p_rd_unmap; pready && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    // a start bit lasts at least one double-speed bit time with divisor zero
    property p_tx_start; $fell(txLine) |-> !txLine[*8]; endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit too short");
    c_err: cover property (pslverr);
    c_tx: cover property ($fell(txLine));
    c_rd: cover property (pready && !pwrite && mapped);
endmodule // umf_top_asserts
bind umf_top umf_top_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
                                    .prdata, .pready, .pslverr, .rxLine, .txLine);

// File: verification/umf_bus_master.sv
// behavioural master node that drives frames onto the shared bus
`timescale 1ns/1ns
module umf_bus_master (
    input wire logic clk,
    output logic     line
);
    // bus idles high between frames
    initial line = 1'h1;
    // start, data lsb first, type bit, closing stop; call just after an edge
    task automatic send(input logic [7:0] d, input int nb, input logic typ, input int bt);
        line <= 1'h0;
        repeat (bt) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            line <= d[i];
            repeat (bt) @(posedge clk);
        end
        line <= typ; // ninth bit or first stop carries the type
        repeat (bt) @(posedge clk);
        line <= 1'h1; // a real stop follows the type bit
        // one more idle bit time so the receiver has stored the frame before the caller polls
        repeat (2 * bt) @(posedge clk);
    endtask
endmodule // umf_bus_master

// File: verification/tb_uart_multidrop_address_filter.sv
// self-checking bench for the multidrop filter serial port
`timescale 1ns/1ns
module tb_uart_multidrop_address_filter
    import umf_pkg::*;
;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxLine;
    logic        txLine;
    logic [31:0] rdData;
    logic        rdErr;
    int          errors = 0;
    int          totalChecks = 0;
    initial forever #50 clk = ~clk;
    umf_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                   .pslverr, .rxLine, .txLine);
    umf_bus_master pm_u (.clk(clk), .line(rxLine));
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdData, exp);
    endtask
    // send one frame and see whether it reached the receive buffer
    task automatic frame(input logic [7:0] d, input int nb, input logic typ, input int bt, input logic kept);
        pm_u.send(d, nb, typ, bt);
        apb(1'h0, UMF_CTRL_STATUS_A, 32'h0);
        chk({31'h0, rdData[UMF_A_RXC]}, {31'h0, kept});
        if (kept) begin
            rd(UMF_DATA, {24'h0, d});
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic testRegs;
        rd(UMF_CTRL_B, {24'h0, UMF_RST_B});
        rd(UMF_DIVISOR, {20'h0, UMF_RST_DIVISOR});
        apb(1'h1, UMF_DIVISOR, 32'h5a3);
        rd(UMF_DIVISOR, 32'h5a3);
        apb(1'h1, UMF_DIVISOR, 32'h0); // exact division, zero rate error
        // the divider reloads only at its next tick, so let the long count run out
        repeat (1500) @(posedge clk);
        apb(1'h1, 12'h010, 32'hff);
        chk({31'h0, rdErr}, 32'h1);
        rd(12'h010, 32'h0);
        $display("test regs done");
    endtask
    task automatic test9;
        apb(1'h1, UMF_CTRL_B, 32'hdc);
        apb(1'h1, UMF_CTRL_STATUS_A, 32'h1); // whole-byte write, no bit twiddling
        frame(8'h55, 8, 1'h0, 16, 1'h0);
        pm_u.send(8'ha3, 8, 1'h1, 16);
        apb(1'h0, UMF_CTRL_B, 32'h0);
        chk({31'h0, rdData[UMF_B_RX8]}, 32'h1);
        rd(UMF_DATA, 32'ha3);
        apb(1'h1, UMF_CTRL_STATUS_A, 32'h0);
        frame(8'h3c, 8, 1'h0, 16, 1'h1);
        frame(8'h81, 8, 1'h1, 16, 1'h1);
        apb(1'h1, UMF_CTRL_STATUS_A, 32'h1);
        frame(8'hc6, 8, 1'h0, 16, 1'h0);
        $display("test nine-bit done");
    endtask
    // every short character size, with the first stop as type bit
    task automatic testSizes;
        logic [7:0] m;
        for (int s = 0; s < 4; s++) begin
            m = 8'hff >> (3 - s);
            apb(1'h1, UMF_CTRL_B, 32'hc0 | (32'(s) << 2));
            frame(8'hb5 & m, 5 + s, 1'h0, 16, 1'h0);
            frame(8'h6a & m, 5 + s, 1'h1, 16, 1'h1);
        end
        $display("test sizes done");
    endtask
    task automatic testDouble;
        apb(1'h1, UMF_CTRL_STATUS_A, 32'h3);
        frame(8'h6e, 8, 1'h0, 8, 1'h0);
        frame(8'hc3, 8, 1'h1, 8, 1'h1);
        $display("test double speed done");
    endtask
    // transmit the same frame with the filter on, off, and as 8-bit with two stops
    task automatic testTx;
        logic [9:0] v;
        int         n;
        for (int f = 0; f < 3; f++) begin
            // writing one to tx complete clears it, in the same whole-byte write
            apb(1'h1, UMF_CTRL_STATUS_A, 32'h40 | 32'(f == 0));
            apb(1'h0, UMF_CTRL_STATUS_A, 32'h0);
            chk({31'h0, rdData[UMF_A_TXC]}, 32'h0);
            apb(1'h1, UMF_CTRL_B, (f < 2) ? 32'hdd : 32'hec);
            apb(1'h1, UMF_DATA, 32'h96);
            n = 0;
            while (txLine !== 1'h0 && n < 400) begin
                @(posedge clk);
                n++;
            end
            repeat (8) @(posedge clk);
            for (int i = 0; i < 10; i++) begin
                v[i] = txLine;
                repeat (16) @(posedge clk);
            end
            repeat (16) @(posedge clk);
            chk({22'h0, v}, {22'h0, 1'h1, 8'h96, 1'h0});
            apb(1'h0, UMF_CTRL_STATUS_A, 32'h0);
            chk({31'h0, rdData[UMF_A_TXC]}, 32'h1);
        end
        $display("test transmit done");
    endtask
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        testRegs;
        test9;
        testSizes;
        testDouble;
        testTx;
        giveVerdict;
    end
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        giveVerdict;
    end
endmodule // tb_uart_multidrop_address_filter
